// File: design/i2c_cfg_params.svh
`ifndef I2C_CFG_PARAMS_SVH
`define I2C_CFG_PARAMS_SVH

// Fixed upper part of the seven-bit slave address, bits 6..3 = 0,1,1,1
`define SLV_ADDR_HI     4'h7
// Strap settle cycles after reset release before the strap is latched
`define STRAP_SETTLE    2'h3

// Bit counter inside one byte slot on the link
`define BIT_LAST        4'h7
`define BIT_ACK         4'h8

// Byte position inside a packet
`define IDX_ADDR        4'h0
`define IDX_CMD0        4'h1
`define IDX_CMD1        4'h2
`define IDX_CMD2        4'h3
`define IDX_CMD3        4'h4
`define IDX_DAT0        4'h5
`define IDX_DAT1        4'h6
`define IDX_DAT2        4'h7
`define IDX_DAT3        4'h8
`define IDX_EXTRA       4'h9

// Command byte fields
`define OPC_MSB         2
`define OPC_LSB         0
`define OPC_WRITE       3'h3
`define PSEL_HI_BIT     0
`define PSEL_LO_BIT     7
`define BE_MSB          5
`define BE_LSB          2
`define AHI_MSB         1
`define AHI_LSB         0
`define PORT_NONE       2'h3

`endif

// File: design/i2c_cfg_pkg.sv
package i2c_cfg_pkg;

    // Command bytes 0..3 and data bytes 0..3 in bus order
    typedef struct packed {
        logic [3:0][7:0] cmd;
        logic [3:0][7:0] dat;
    } pkt_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  port;
        logic [11:0] addr;
        logic [3:0]  be;
        logic [31:0] data;
    } wr_req_s;

    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_RUN  = 2'b01,
        LINK_REARM = 2'b10
    } link_state_e;

endpackage

// File: design/i2c_config_register_write_slave.sv
`timescale 1ns/1ps
`include "i2c_cfg_params.svh"

// Notes on behaviour
// - Slave address bits 2..0 come from the three strap pins, low to high.
// - Address bits 5..3 are one, bit 6 zero; only that address is answered.
// - Packet is address byte, four command bytes, then data; position decides meaning.
// - Packet opens with START, closes with STOP; each byte gets an ack bit.
// - An invalid command leaves the targeted register untouched.
// - Data bytes go to register bits 31:24, 23:16, 15:8, 7:0 in order.
// - Every data byte beyond the fourth is answered with a negative acknowledge.
// - Command byte 0 bits 2..0 are the opcode; 011b means register write.
// - Port selector is command byte 1 bit 0 (high), byte 2 bit 7 (low).
// - The write goes to the port numbered by the selector, 0 to 2.
// - Command byte 2 bits 5..2 enable register bytes 3..0 individually.
// - Byte address is byte 2 bits 1..0, then byte 3, then two zeros.
// - Writes work independently of the upstream serial link state.
module i2c_config_register_write_slave (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        sideband_clock_pin,
    input  wire logic        sideband_data_pin_in,
    output      logic        sideband_data_pin_out,
    output      logic        sideband_data_pin_oe,
    input  wire logic [2:0]  addr_strap_pin,
    output      logic        cfg_wr_strobe,
    output      logic [1:0]  cfg_wr_port,
    output      logic [11:0] cfg_wr_addr,
    output      logic [3:0]  cfg_wr_be,
    output      logic [31:0] cfg_wr_data,
    output      logic        cfg_cmd_reject,
    output      logic        frame_active
);

    // Reference clock side
    logic [1:0]                 rst_pipe;
    logic                       rst_n;
    logic [4:0]                 pin_s;
    logic                       scl_s;
    logic                       sda_s;
    logic                       scl_q;
    logic                       sda_q;
    logic                       start_det;
    logic                       stop_det;
    i2c_cfg_pkg::link_state_e   link_state;
    i2c_cfg_pkg::link_state_e   next_link_state;
    logic                       link_rst;
    logic                       next_link_rst;
    logic                       next_frame_active;
    logic [1:0]                 strap_cnt;
    logic [1:0]                 next_strap_cnt;
    logic                       strap_taken;
    logic                       next_strap_taken;
    logic [2:0]                 slave_lo;
    logic [2:0]                 next_slave_lo;
    logic                       req_s;
    logic                       req_q;
    logic                       new_req;
    i2c_cfg_pkg::wr_req_s       dec;
    logic                       next_cfg_wr_strobe;
    logic                       next_cfg_cmd_reject;
    logic [1:0]                 next_cfg_wr_port;
    logic [11:0]                next_cfg_wr_addr;
    logic [3:0]                 next_cfg_wr_be;
    logic [31:0]                next_cfg_wr_data;

    // Link clock side
    logic [3:0]                 bitcnt;
    logic [3:0]                 next_bitcnt;
    logic [3:0]                 idx;
    logic [3:0]                 next_idx;
    logic [6:0]                 shreg;
    logic [6:0]                 next_shreg;
    logic                       matched;
    logic                       next_matched;
    logic [7:0]                 byte_full;
    logic                       byte_done;
    i2c_cfg_pkg::pkt_s          pkt;
    i2c_cfg_pkg::pkt_s          next_pkt;
    logic                       req_tgl;
    logic                       next_req_tgl;
    logic                       next_data_oe;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_n = rst_pipe[1];

    level_sync #(
        .WIDTH (5)
    ) u_pin_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     ({addr_strap_pin, sideband_clock_pin, sideband_data_pin_in}),
        .q     (pin_s)
    );

    level_sync #(
        .WIDTH (1)
    ) u_req_sync (
        .clk   (ref_clk),
        .rst_n (rst_n),
        .d     (req_tgl),
        .q     (req_s)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    // Frame control: START and STOP are seen on the reference clock, because the
    // link clock gives no edge around them. The link logic is held in reset
    // outside frames and released while the clock line is still high.
    always_comb begin
        start_det         = scl_s && scl_q && sda_q && !sda_s;
        stop_det          = scl_s && scl_q && !sda_q && sda_s;
        next_link_state   = link_state;
        next_strap_cnt    = strap_cnt;
        next_strap_taken  = strap_taken;
        next_slave_lo     = slave_lo;
        if (strap_cnt != `STRAP_SETTLE) begin
            next_strap_cnt = strap_cnt + 2'h1;
        end else if (!strap_taken) begin
            next_strap_taken = 1'b1;
            next_slave_lo    = pin_s[4:2];
        end
        case (link_state)
            i2c_cfg_pkg::LINK_IDLE: begin
                if (start_det && strap_taken) begin
                    next_link_state = i2c_cfg_pkg::LINK_RUN;
                end
            end
            i2c_cfg_pkg::LINK_RUN: begin
                if (stop_det) begin
                    next_link_state = i2c_cfg_pkg::LINK_IDLE;
                end else if (start_det) begin
                    // Repeated START restarts byte counting
                    next_link_state = i2c_cfg_pkg::LINK_REARM;
                end
            end
            i2c_cfg_pkg::LINK_REARM: begin
                if (stop_det) begin
                    next_link_state = i2c_cfg_pkg::LINK_IDLE;
                end else begin
                    next_link_state = i2c_cfg_pkg::LINK_RUN;
                end
            end
            default: begin
                next_link_state = i2c_cfg_pkg::LINK_IDLE;
            end
        endcase
        next_link_rst     = (next_link_state != i2c_cfg_pkg::LINK_RUN);
        next_frame_active = !next_link_rst;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q        <= 1'b1;
            sda_q        <= 1'b1;
            link_state   <= i2c_cfg_pkg::LINK_IDLE;
            link_rst     <= 1'b1;
            frame_active <= 1'b0;
            strap_cnt    <= 2'h0;
            strap_taken  <= 1'b0;
            slave_lo     <= 3'h0;
        end else begin
            scl_q        <= scl_s;
            sda_q        <= sda_s;
            link_state   <= next_link_state;
            link_rst     <= next_link_rst;
            frame_active <= next_frame_active;
            strap_cnt    <= next_strap_cnt;
            strap_taken  <= next_strap_taken;
            slave_lo     <= next_slave_lo;
        end
    end

    wr_decode u_decode (
        .pkt (pkt),
        .req (dec)
    );

    // Commit: the packet words are stable long before the next packet can touch
    // them, so the toggle alone is synchronised. No link-up term gates this path.
    always_comb begin
        new_req             = req_s ^ req_q;
        next_cfg_wr_strobe  = new_req && dec.valid;
        next_cfg_cmd_reject = new_req && !dec.valid;
        next_cfg_wr_port    = cfg_wr_port;
        next_cfg_wr_addr    = cfg_wr_addr;
        next_cfg_wr_be      = cfg_wr_be;
        next_cfg_wr_data    = cfg_wr_data;
        if (new_req && dec.valid) begin
            next_cfg_wr_port = dec.port;
            next_cfg_wr_addr = dec.addr;
            next_cfg_wr_be   = dec.be;
            next_cfg_wr_data = dec.data;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q          <= 1'b0;
            cfg_wr_strobe  <= 1'b0;
            cfg_cmd_reject <= 1'b0;
            cfg_wr_port    <= 2'h0;
            cfg_wr_addr    <= 12'h000;
            cfg_wr_be      <= 4'h0;
            cfg_wr_data    <= 32'h00000000;
        end else begin
            req_q          <= req_s;
            cfg_wr_strobe  <= next_cfg_wr_strobe;
            cfg_cmd_reject <= next_cfg_cmd_reject;
            cfg_wr_port    <= next_cfg_wr_port;
            cfg_wr_addr    <= next_cfg_wr_addr;
            cfg_wr_be      <= next_cfg_wr_be;
            cfg_wr_data    <= next_cfg_wr_data;
        end
    end

    // Link side: bits are taken on rising clock edges
    always_comb begin
        byte_full    = {shreg, sideband_data_pin_in};
        byte_done    = (bitcnt == `BIT_LAST);
        next_bitcnt  = (bitcnt == `BIT_ACK) ? 4'h0 : bitcnt + 4'h1;
        next_shreg   = (bitcnt < `BIT_ACK) ? byte_full[6:0] : shreg;
        next_idx     = idx;
        if (bitcnt == `BIT_ACK && idx != `IDX_EXTRA) begin
            next_idx = idx + 4'h1;
        end
        next_matched = matched;
        if (byte_done && idx == `IDX_ADDR) begin
            // Reads are not served here, so a set direction bit is not ours
            next_matched = (byte_full[7:1] == {`SLV_ADDR_HI, slave_lo})
                           && !byte_full[0];
        end
    end

    always_ff @(posedge sideband_clock_pin or posedge link_rst) begin
        if (link_rst) begin
            bitcnt  <= 4'h0;
            idx     <= `IDX_ADDR;
            shreg   <= 7'h00;
            matched <= 1'b0;
        end else begin
            bitcnt  <= next_bitcnt;
            idx     <= next_idx;
            shreg   <= next_shreg;
            matched <= next_matched;
        end
    end

    // Payload sits outside the frame reset so it stays stable for the crossing
    always_comb begin
        next_pkt     = pkt;
        next_req_tgl = req_tgl;
        if (byte_done && matched) begin
            case (idx)
                `IDX_CMD0: next_pkt.cmd[0] = byte_full;
                `IDX_CMD1: next_pkt.cmd[1] = byte_full;
                `IDX_CMD2: next_pkt.cmd[2] = byte_full;
                `IDX_CMD3: next_pkt.cmd[3] = byte_full;
                `IDX_DAT0: next_pkt.dat[0] = byte_full;
                `IDX_DAT1: next_pkt.dat[1] = byte_full;
                `IDX_DAT2: next_pkt.dat[2] = byte_full;
                `IDX_DAT3: next_pkt.dat[3] = byte_full;
                default:   next_pkt = pkt;
            endcase
            if (idx == `IDX_DAT3) begin
                next_req_tgl = !req_tgl;
            end
        end
    end

    always_ff @(posedge sideband_clock_pin or negedge rst_n) begin
        if (!rst_n) begin
            pkt     <= '0;
            req_tgl <= 1'b0;
        end else begin
            pkt     <= next_pkt;
            req_tgl <= next_req_tgl;
        end
    end

    // Acknowledge driven from the falling edge so data is set up for the master
    always_comb begin
        next_data_oe = (bitcnt == `BIT_ACK) && matched
                       && (idx <= `IDX_DAT3);
    end

    always_ff @(negedge sideband_clock_pin or posedge link_rst) begin
        if (link_rst) begin
            sideband_data_pin_oe <= 1'b0;
        end else begin
            sideband_data_pin_oe <= next_data_oe;
        end
    end

    // Open-drain: only ever pulls low
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sideband_data_pin_out <= 1'b0;
        end else begin
            sideband_data_pin_out <= 1'b0;
        end
    end

endmodule // i2c_config_register_write_slave

// File: design/level_sync.sv
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] d,
    output      logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule // level_sync

// File: design/wr_decode.sv
`timescale 1ns/1ps
`include "i2c_cfg_params.svh"

module wr_decode (
    input  wire i2c_cfg_pkg::pkt_s    pkt,
    output      i2c_cfg_pkg::wr_req_s req
);

    logic [2:0] opcode;
    logic [1:0] port;

    always_comb begin
        opcode    = pkt.cmd[0][`OPC_MSB:`OPC_LSB];
        port      = {pkt.cmd[1][`PSEL_HI_BIT], pkt.cmd[2][`PSEL_LO_BIT]};
        req.port  = port;
        req.be    = pkt.cmd[2][`BE_MSB:`BE_LSB];
        req.addr  = {pkt.cmd[2][`AHI_MSB:`AHI_LSB], pkt.cmd[3], 2'h0};
        // First data byte lands in the top byte
        req.data  = {pkt.dat[0], pkt.dat[1], pkt.dat[2], pkt.dat[3]};
        req.valid = (opcode == `OPC_WRITE) && (port != `PORT_NONE);
    end

endmodule // wr_decode

// File: sim/bus_master_model.sv
`timescale 1ns/1ps
module bus_master_model (
    output      logic scl,
    output      logic sda_drv,
    input  wire logic sda
);
    logic [7:0] tx_byte [0:10];
    logic       ack_bit [0:10];

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    // Data moves only while the clock is low
    task automatic put_bit(input logic b, output logic r);
        #40 sda_drv = b;
        #40 scl = 1'b1;
        #40 r = sda;
        #40 scl = 1'b0;
    endtask

    // Same entry serves START and repeated START
    task automatic xfer(input int n, input bit with_stop);
        logic r;
        #13 sda_drv = 1'b1;
        #80 scl = 1'b1;
        #240 sda_drv = 1'b0;
        #240 scl = 1'b0;
        for (int i = 0; i < n; i++) begin
            for (int k = 7; k >= 0; k--) put_bit(tx_byte[i][k], r);
            put_bit(1'b1, ack_bit[i]);
        end
        if (with_stop) begin
            #40 sda_drv = 1'b0;
            #40 scl = 1'b1;
            #240 sda_drv = 1'b1;
            #240;
        end
    endtask
endmodule // bus_master_model

// File: sim/i2c_cfg_properties.sv
`timescale 1ns/1ps
module i2c_cfg_properties (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        sideband_clock_pin,
    input wire logic        sideband_data_pin_in,
    input wire logic        sideband_data_pin_out,
    input wire logic        sideband_data_pin_oe,
    input wire logic [2:0]  addr_strap_pin,
    input wire logic        cfg_wr_strobe,
    input wire logic [1:0]  cfg_wr_port,
    input wire logic [11:0] cfg_wr_addr,
    input wire logic [3:0]  cfg_wr_be,
    input wire logic [31:0] cfg_wr_data,
    input wire logic        cfg_cmd_reject,
    input wire logic        frame_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    a_strobe_pulse: assert property (cfg_wr_strobe |=> !cfg_wr_strobe)
        else $error("write strobe too long");
    a_reject_pulse: assert property (cfg_cmd_reject |=> !cfg_cmd_reject)
        else $error("reject pulse too long");
    a_single_outcome: assert property (!(cfg_wr_strobe && cfg_cmd_reject))
        else $error("strobe and reject together");
    a_addr_aligned: assert property (cfg_wr_strobe |-> cfg_wr_addr[1:0] == 2'h0)
        else $error("address low bits not zero");
    a_port_valid: assert property (cfg_wr_strobe |-> cfg_wr_port != 2'h3)
        else $error("write to port three");
    a_fields_hold: assert property (!cfg_wr_strobe |->
        $stable({cfg_wr_port, cfg_wr_addr, cfg_wr_be, cfg_wr_data}))
        else $error("fields changed without strobe");
    a_ack_in_frame: assert property (sideband_data_pin_oe |-> frame_active)
        else $error("data driven outside frame");
    a_ack_low: assert property (sideband_data_pin_oe |-> !sideband_data_pin_out)
        else $error("driven data not low");
    a_ack_clk_low: assert property ($changed(sideband_data_pin_oe) |->
        !sideband_clock_pin)
        else $error("data enable moved while clock high");
    a_frame_open: assert property ($fell(sideband_data_pin_in) &&
        sideband_clock_pin && $past(sideband_clock_pin) |-> ##[0:4] frame_active)
        else $error("start not seen");
    a_frame_close: assert property ($rose(sideband_data_pin_in) &&
        sideband_clock_pin && $past(sideband_clock_pin) |-> ##[1:5] !frame_active)
        else $error("stop not seen");
endmodule // i2c_cfg_properties

bind i2c_config_register_write_slave i2c_cfg_properties u_props (
    .ref_clk, .arst_n, .sideband_clock_pin, .sideband_data_pin_in,
    .sideband_data_pin_out, .sideband_data_pin_oe, .addr_strap_pin,
    .cfg_wr_strobe, .cfg_wr_port, .cfg_wr_addr, .cfg_wr_be, .cfg_wr_data,
    .cfg_cmd_reject, .frame_active
);

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk;
    logic        arst_n;
    logic        scl;
    logic        sda_drv;
    logic        sda;
    logic        sda_out;
    logic        sda_oe;
    logic [2:0]  strap;
    logic        wr_strobe;
    logic [1:0]  wr_port;
    logic [11:0] wr_addr;
    logic [3:0]  wr_be;
    logic [31:0] wr_data;
    logic        reject;
    logic        frame;
    logic [49:0] exp_f;
    int          err_total;
    int          checks;
    int          seed;
    int          n_wr;
    int          n_rej;

    // Open drain with pull-up
    assign sda = sda_drv & ~(sda_oe & ~sda_out);

    i2c_config_register_write_slave u_i2c_config_register_write_slave (
        .ref_clk(ref_clk), .arst_n(arst_n), .sideband_clock_pin(scl),
        .sideband_data_pin_in(sda), .sideband_data_pin_out(sda_out),
        .sideband_data_pin_oe(sda_oe), .addr_strap_pin(strap),
        .cfg_wr_strobe(wr_strobe), .cfg_wr_port(wr_port), .cfg_wr_addr(wr_addr),
        .cfg_wr_be(wr_be), .cfg_wr_data(wr_data), .cfg_cmd_reject(reject),
        .frame_active(frame)
    );
    bus_master_model u_bus_master_model (.scl(scl), .sda_drv(sda_drv), .sda(sda));

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (wr_strobe === 1'b1) n_wr++;
        if (reject === 1'b1) n_rej++;
    end

    task automatic chk(input string what, input logic [49:0] exp, input logic [49:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    // One compare task per kind of result, all feeding the same tally
    task automatic chk_ack(input int idx, input logic exp, input logic got);
        chk($sformatf("ack byte %0d", idx), 50'(exp), 50'(got));
    endtask

    task automatic chk_count(input string what, input logic [31:0] exp, input logic [31:0] got);
        chk(what, 50'(exp), 50'(got));
    endtask

    task automatic chk_fields(input logic [49:0] exp, input logic [49:0] got);
        chk("fields", exp, got);
    endtask

    // Expectations come from the command rules, not from the design
    function automatic bit cmd_ok(input logic [2:0] opc, input logic [1:0] p);
        return (opc == 3'h3) && (p != 2'h3);
    endfunction

    function automatic logic ack_of(input bit bad, input int i);
        // Address, four command and four data bytes are acked; extras are not
        return !(!bad && i < 9);
    endfunction

    function automatic logic [49:0] fields_of(input logic [1:0] p, input logic [9:0] a,
                                              input logic [3:0] be, input logic [31:0] d);
        return {p, a, 2'h0, be, d};
    endfunction

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic run(input string nm, input logic [2:0] opc, input logic [1:0] p,
                       input logic [3:0] be, input logic [9:0] a, input logic [31:0] d,
                       input int nd, input bit stp, input bit bad);
        logic [7:0] b [0:10];
        int         w0;
        int         r0;
        bit         ok;
        bit         com;
        w0 = n_wr;
        r0 = n_rej;
        ok = cmd_ok(opc, p);
        com = !bad && nd >= 4;
        b[0] = {1'b0, 3'b111, strap[2], strap[1], strap[0] ^ bad, 1'b0};
        b[1] = {5'($random(seed)), opc};
        b[2] = {2'($random(seed)), 5'h00, p[1]};
        b[3] = {p[0], 1'($random(seed)), be, a[9:8]};
        b[4] = a[7:0];
        for (int i = 0; i < 6; i++) b[5 + i] = d[31 - 8 * (i % 4) -: 8];
        for (int i = 0; i < 11; i++) u_bus_master_model.tx_byte[i] = b[i];
        u_bus_master_model.xfer(5 + nd, stp);
        repeat (10) @(posedge ref_clk);
        for (int i = 0; i < 5 + nd; i++)
            chk_ack(i, ack_of(bad, i), u_bus_master_model.ack_bit[i]);
        if (com && ok) exp_f = fields_of(p, a, be, d);
        chk_count("strobes", 32'(com && ok), 32'(n_wr - w0));
        chk_count("rejects", 32'(com && !ok), 32'(n_rej - r0));
        chk_fields(exp_f, {wr_port, wr_addr, wr_be, wr_data});
        $display("test %s done", nm);
    endtask

    initial begin
        seed = 63;
        err_total = 0;
        checks = 0;
        n_wr = 0;
        n_rej = 0;
        exp_f = '0;
        arst_n = 1'b0;
        strap = 3'($random(seed));
        repeat (12) @(posedge ref_clk);
        #13 arst_n = 1'b1;
        repeat (20) @(posedge ref_clk);
        run("walk", 3'h3, 2'h0, 4'hF, 10'h02D, 32'h12345678, 4, 1, 0);
        for (int p = 0; p < 4; p++)
            run("port", 3'h3, 2'(p), 4'($random(seed)), 10'($random(seed)),
                $random(seed), 4, 1, 0);
        for (int o = 0; o < 8; o++)
            run("opcode", 3'(o), 2'({$random(seed)} % 3), 4'hA, 10'($random(seed)),
                $random(seed), 4, 1, 0);
        run("extra", 3'h3, 2'h2, 4'h5, 10'h3FF, $random(seed), 6, 1, 0);
        run("short", 3'h3, 2'h1, 4'hF, 10'h001, $random(seed), 3, 1, 0);
        run("bad_addr", 3'h3, 2'h1, 4'hF, 10'h010, $random(seed), 4, 1, 1);
        run("no_stop", 3'h3, 2'h1, 4'h3, 10'h200, $random(seed), 4, 0, 0);
        run("rstart", 3'h3, 2'h2, 4'hC, 10'h100, $random(seed), 4, 1, 0);
        for (int k = 0; k < 6; k++)
            run("random", 3'($random(seed)), 2'($random(seed)), 4'($random(seed)),
                10'($random(seed)), $random(seed), 4, 1, 0);
        print_verdict();
    end

    initial begin
        #3000000;
        err_total++;
        print_verdict();
    end
endmodule // tb_top
